// ===== rtl/dmd_pkg.sv
// data memory decoder package: address map, reset values, field positions, types
// assumes an 8-bit data space shared by the core, the RAM and the special registers
package dmd_pkg;
	localparam int          RAM_BYTES        = 256;
	localparam int          ADDR_W           = 8;
	localparam logic [7:0]  UPPER_HALF_BASE  = 8'h80;
	localparam logic [7:0]  BIT_BYTE_BASE    = 8'h20;
	localparam logic [7:0]  STACK_PTR_ADDR   = 8'h81;
	localparam logic [7:0]  STATUS_WORD_ADDR = 8'hD0;
	localparam logic [7:0]  STACK_PTR_RESET  = 8'h07;
	localparam logic [7:0]  STATUS_RESET     = 8'h00;
	localparam int          BANK_SEL_LOW_POS  = 3;
	localparam int          BANK_SEL_HIGH_POS = 4;
	localparam logic [2:0]  BANK_REG_ZERO    = 3'h0;

	// operand addressing: direct byte/bit, pointer through a bank register, bank register
	typedef enum logic [1:0] {
		MODE_DIRECT,
		MODE_INDIRECT,
		MODE_REG
	} dmd_mode_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PTR,
		ST_ADDR,
		ST_SPEC_WAIT,
		ST_READ
	} dmd_state_t;

	// byte address of register idx in a bank: banks are eight bytes from address zero
	function automatic logic [7:0] bank_addr(input logic [1:0] bank, input logic [2:0] idx);
		bank_addr = {3'h0, bank, idx};
	endfunction
endpackage

// ===== rtl/dmd_if.sv
// carriers between the decoder top and its RAM and address-map submodules
// assumes one clock; the RAM answers one cycle after the address
`timescale 1ns/1ps
`default_nettype none
interface dmd_ram_if;
	logic [7:0] addr;
	logic       we;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport ctrl (output addr, output we, output wdata, input rdata);
	modport mem  (input addr, input we, input wdata, output rdata);
endinterface // dmd_ram_if

interface dmd_map_if;
	dmd_pkg::dmd_mode_t mode;
	logic [7:0]         addr;
	logic               isBit;
	logic [1:0]         bank;
	logic               toSpec;
	logic [7:0]         byteAddr;
	logic [2:0]         bitPos;
	modport ctrl (output mode, output addr, output isBit, output bank,
	              input toSpec, input byteAddr, input bitPos);
	modport map  (input mode, input addr, input isBit, input bank,
	              output toSpec, output byteAddr, output bitPos);
endinterface // dmd_map_if
`default_nettype wire

// ===== rtl/dmd_ram.sv
// internal data RAM: one write port, synchronous read
// assumes the controller holds the address for the cycle it needs data
`timescale 1ns/1ps
`default_nettype none
module dmd_ram #(
	parameter int DEPTH = dmd_pkg::RAM_BYTES
) (
	input  wire logic clk_sys,
	dmd_ram_if.mem    ram
);
	logic [7:0] store [DEPTH];
	logic [7:0] rdata_ff;

	// full 256-byte array, both halves in one store
	always_ff @(posedge clk_sys) begin
		if (ram.we) begin
			store[ram.addr] <= ram.wdata;
		end
		rdata_ff <= store[ram.addr];
	end

	assign ram.rdata = rdata_ff;
endmodule // dmd_ram
`default_nettype wire

// ===== rtl/dmd_addr_map.sv
// address map: steers an operand to RAM or special space, and splits bit addresses
// assumes indirect operands arrive already resolved to the pointer value
`timescale 1ns/1ps
`default_nettype none
module dmd_addr_map (
	dmd_map_if.map m
);
	logic       bitInRam;
	logic [7:0] bitByte;
	logic [7:0] byteTarget;
	logic       byteToSpec;

	// bit operands: low half maps into 0x20..0x2F, high half into x0/x8 registers
	assign bitInRam   = ~m.addr[7];
	assign bitByte    = bitInRam ? 8'(dmd_pkg::BIT_BYTE_BASE + {4'h0, m.addr[6:3]})
	                             : {m.addr[7:3], 3'h0};

	// byte operands: direct high addresses are special, indirect ones are RAM
	assign byteToSpec = (m.mode == dmd_pkg::MODE_DIRECT) && m.addr[7];
	assign byteTarget = (m.mode == dmd_pkg::MODE_REG) ? dmd_pkg::bank_addr(m.bank, m.addr[2:0])
	                                                 : m.addr;

	// operand type, not address, picks bit or byte decoding
	assign m.toSpec   = m.isBit ? ~bitInRam : byteToSpec;
	assign m.byteAddr = m.isBit ? bitByte : byteTarget;
	assign m.bitPos   = m.isBit ? m.addr[2:0] : 3'h0;
endmodule // dmd_addr_map
`default_nettype wire

// ===== rtl/dmd_decoder.sv
// data memory decoder top: RAM, bank registers, bit space, stack pointer, status word
// assumes the core issues one request at a time while accReady is high
// assumes peripherals return specRdData in the cycle after specRdEn
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - holds 256 bytes of data RAM at addresses 0x00 to 0xFF
// - lower 128 bytes reachable by direct and indirect addressing
// - upper 128 RAM bytes only indirect, separate from special registers
// - direct access at 0x80..0xFF goes to special register space
// - indirect access above 0x7F goes to upper RAM, never special space
// - 0x00..0x1F form four banks of eight byte registers
// - status word bits 3 and 4 pick the one active bank
// - indirect pointer comes from bank register zero or one of active bank
// - bytes 0x20..0x2F also reachable as 128 bits, addresses 0x00..0x7F
// - bit address is eight times byte offset from 0x20 plus position
// - operand type, not address, decides bit or byte access
// - stack pointer marks last used; push writes at pointer plus one, increments
// - reset loads stack pointer with 0x07, first push lands at 0x08
// - stack may sit anywhere in the full 256-byte RAM
// - stack pointer readable and writable directly at 0x81
// - only special registers at x0 or x8 take bit access
module dmd_decoder (
	input  wire logic               clk_sys,
	input  wire logic               rst_b,
	input  wire logic               accReq,
	input  wire dmd_pkg::dmd_mode_t accMode,
	input  wire logic               accIsBit,
	input  wire logic               accWrite,
	input  wire logic [7:0]         accAddr,
	input  wire logic [7:0]         accWrData,
	input  wire logic               pushReq,
	input  wire logic               popReq,
	output logic                    accReady,
	output logic                    accDone,
	output logic [7:0]              accRdData,
	output logic [7:0]              stackPointer,
	output logic [7:0]              statusWord,
	output logic [1:0]              bankSel,
	output logic                    specRdEn,
	output logic                    specWrEn,
	output logic [7:0]              specAddr,
	output logic [7:0]              specWrData,
	input  wire logic [7:0]         specRdData
);
	dmd_ram_if ramBus ();
	dmd_map_if mapBus ();

	dmd_pkg::dmd_state_t state_ff;
	dmd_pkg::dmd_state_t nxt_state;
	dmd_pkg::dmd_mode_t  mode_ff;
	logic       isBit_ff;
	logic       write_ff;
	logic       push_ff;
	logic       pop_ff;
	logic [7:0] opAddr_ff;
	logic [7:0] wrData_ff;
	logic [7:0] ptr_ff;
	logic [7:0] effAddr_ff;
	logic       effSpec_ff;
	logic [2:0] bitPos_ff;
	logic [7:0] stackPtr_ff;
	logic [7:0] status_ff;
	logic       ready_ff;
	logic       done_ff;
	logic [7:0] rdData_ff;
	logic       specRd_ff;
	logic       specWr_ff;
	logic [7:0] specAddr_ff;
	logic [7:0] specWrData_ff;

	dmd_ram u_ram (
		.clk_sys (clk_sys),
		.ram     (ramBus)
	);

	dmd_addr_map u_map (
		.m (mapBus)
	);

	// request acceptance, operand after pointer resolution
	logic       take;
	logic [1:0] bank;
	assign take = ready_ff && (accReq || pushReq || popReq);
	assign bank = {status_ff[dmd_pkg::BANK_SEL_HIGH_POS], status_ff[dmd_pkg::BANK_SEL_LOW_POS]};

	assign mapBus.mode  = mode_ff;
	assign mapBus.addr  = (mode_ff == dmd_pkg::MODE_INDIRECT) ? ptr_ff : opAddr_ff;
	assign mapBus.isBit = isBit_ff;
	assign mapBus.bank  = bank;

	// target of the access: stack ops always hit RAM at any address
	logic       stackOp;
	logic       tgtSpec;
	logic [7:0] tgtAddr;
	assign stackOp = push_ff || pop_ff;
	assign tgtSpec = stackOp ? 1'b0 : mapBus.toSpec;
	assign tgtAddr = push_ff ? 8'(stackPtr_ff + 8'h01)
	               : pop_ff  ? stackPtr_ff
	               : mapBus.byteAddr;

	// special registers kept inside this block
	logic tgtIsStack;
	logic tgtIsStatus;
	logic effIsStack;
	logic effIsStatus;
	assign tgtIsStack  = tgtSpec && (tgtAddr == dmd_pkg::STACK_PTR_ADDR);
	assign tgtIsStatus = tgtSpec && (tgtAddr == dmd_pkg::STATUS_WORD_ADDR);
	assign effIsStack  = effSpec_ff && (effAddr_ff == dmd_pkg::STACK_PTR_ADDR);
	assign effIsStatus = effSpec_ff && (effAddr_ff == dmd_pkg::STATUS_WORD_ADDR);

	// read needed for every read and for a bit write (read-modify-write)
	logic needRead;
	assign needRead = !write_ff || isBit_ff;

	// byte fetched in the read state and the byte a bit write produces
	logic [7:0] curByte;
	logic [7:0] bitMask;
	logic [7:0] mergedByte;
	assign curByte    = !effSpec_ff ? ramBus.rdata
	                  : effIsStack  ? stackPtr_ff
	                  : effIsStatus ? status_ff
	                  : specRdData;
	assign bitMask    = 8'h01 << bitPos_ff;
	assign mergedByte = wrData_ff[0] ? (curByte | bitMask) : (curByte & ~bitMask);

	// write commit point and data
	logic       wrNow;
	logic [7:0] wrByte;
	logic       wrSpec;
	logic [7:0] wrAddr;
	assign wrNow  = ((state_ff == dmd_pkg::ST_ADDR) && !needRead)
	             || ((state_ff == dmd_pkg::ST_READ) && write_ff);
	assign wrByte = (state_ff == dmd_pkg::ST_READ) ? mergedByte : wrData_ff;
	assign wrSpec = (state_ff == dmd_pkg::ST_READ) ? effSpec_ff : tgtSpec;
	assign wrAddr = (state_ff == dmd_pkg::ST_READ) ? effAddr_ff : tgtAddr;

	logic wrStack;
	logic wrStatus;
	logic wrExt;
	assign wrStack  = wrNow && wrSpec && (wrAddr == dmd_pkg::STACK_PTR_ADDR);
	assign wrStatus = wrNow && wrSpec && (wrAddr == dmd_pkg::STATUS_WORD_ADDR);
	assign wrExt    = wrNow && wrSpec && !wrStack && !wrStatus;

	// external special read launch, only for addresses not held here
	logic rdExt;
	assign rdExt = (state_ff == dmd_pkg::ST_ADDR) && needRead && tgtSpec && !tgtIsStack && !tgtIsStatus;

	// RAM port: pointer fetch at accept, target read at address step, write at commit
	assign ramBus.addr  = (state_ff == dmd_pkg::ST_IDLE) ? dmd_pkg::bank_addr(bank, {2'h0, accAddr[0]})
	                    : wrNow ? wrAddr
	                    : tgtAddr;
	assign ramBus.we    = wrNow && !wrSpec;
	assign ramBus.wdata = wrByte;

	// stack pointer movement: push on the same edge as its write, pop after its read
	logic       finish;
	logic       spInc;
	logic       spDec;
	logic [7:0] nxt_stackPtr;
	assign finish = ((state_ff == dmd_pkg::ST_ADDR) && !needRead) || (state_ff == dmd_pkg::ST_READ);
	assign spInc  = finish && push_ff;
	assign spDec  = finish && pop_ff;
	assign nxt_stackPtr = wrStack ? wrByte
	                    : spInc   ? 8'(stackPtr_ff + 8'h01)
	                    : spDec   ? 8'(stackPtr_ff - 8'h01)
	                    : stackPtr_ff;

	// sequencing: idle, pointer fetch, address step, optional wait, read/merge
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			dmd_pkg::ST_IDLE: begin
				if (take) begin
					nxt_state = (accReq && accMode == dmd_pkg::MODE_INDIRECT) ? dmd_pkg::ST_PTR : dmd_pkg::ST_ADDR;
				end
			end
			dmd_pkg::ST_PTR: begin
				nxt_state = dmd_pkg::ST_ADDR;
			end
			dmd_pkg::ST_ADDR: begin
				if (!needRead) begin
					nxt_state = dmd_pkg::ST_IDLE;
				end else if (rdExt) begin
					nxt_state = dmd_pkg::ST_SPEC_WAIT;
				end else begin
					nxt_state = dmd_pkg::ST_READ;
				end
			end
			dmd_pkg::ST_SPEC_WAIT: begin
				nxt_state = dmd_pkg::ST_READ;
			end
			dmd_pkg::ST_READ: begin
				nxt_state = dmd_pkg::ST_IDLE;
			end
			default: begin
				nxt_state = dmd_pkg::ST_IDLE;
			end
		endcase
	end

	// read result: single bit lands in bit 0
	logic [7:0] nxt_rdData;
	assign nxt_rdData = isBit_ff ? {7'h00, curByte[bitPos_ff]} : curByte;

	// state and handshake
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			state_ff <= dmd_pkg::ST_IDLE;
			ready_ff <= 1'b0;
			done_ff  <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			ready_ff <= (nxt_state == dmd_pkg::ST_IDLE);
			done_ff  <= finish;
		end
	end

	// request capture; push wins over pop, access over both
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			mode_ff   <= dmd_pkg::MODE_DIRECT;
			isBit_ff  <= 1'b0;
			write_ff  <= 1'b0;
			push_ff   <= 1'b0;
			pop_ff    <= 1'b0;
			opAddr_ff <= 8'h00;
			wrData_ff <= 8'h00;
		end else if (take) begin
			mode_ff   <= accReq ? accMode : dmd_pkg::MODE_INDIRECT;
			isBit_ff  <= accReq && accIsBit && (accMode == dmd_pkg::MODE_DIRECT);
			write_ff  <= accReq ? accWrite : pushReq;
			push_ff   <= !accReq && pushReq;
			pop_ff    <= !accReq && !pushReq;
			opAddr_ff <= accAddr;
			wrData_ff <= accWrData;
		end
	end

	// pointer byte arrives from the active bank one cycle after accept
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			ptr_ff <= 8'h00;
		end else if (state_ff == dmd_pkg::ST_PTR) begin
			ptr_ff <= ramBus.rdata;
		end
	end

	// resolved target held for the read and merge steps
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			effAddr_ff <= 8'h00;
			effSpec_ff <= 1'b0;
			bitPos_ff  <= 3'h0;
		end else if (state_ff == dmd_pkg::ST_ADDR) begin
			effAddr_ff <= tgtAddr;
			effSpec_ff <= tgtSpec;
			bitPos_ff  <= stackOp ? 3'h0 : mapBus.bitPos;
		end
	end

	// stack pointer and status word
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			stackPtr_ff <= dmd_pkg::STACK_PTR_RESET;
			status_ff   <= dmd_pkg::STATUS_RESET;
		end else begin
			stackPtr_ff <= nxt_stackPtr;
			if (wrStatus) begin
				status_ff <= wrByte;
			end
		end
	end

	// read data returned to the core
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			rdData_ff <= 8'h00;
		end else if ((state_ff == dmd_pkg::ST_READ) && !write_ff) begin
			rdData_ff <= nxt_rdData;
		end
	end

	// peripheral register strobes: decode only, registers live outside
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			specRd_ff     <= 1'b0;
			specWr_ff     <= 1'b0;
			specAddr_ff   <= 8'h00;
			specWrData_ff <= 8'h00;
		end else begin
			specRd_ff <= rdExt;
			specWr_ff <= wrExt;
			if (rdExt || wrExt) begin
				specAddr_ff <= rdExt ? tgtAddr : wrAddr;
			end
			if (wrExt) begin
				specWrData_ff <= wrByte;
			end
		end
	end

	assign accReady     = ready_ff;
	assign accDone      = done_ff;
	assign accRdData    = rdData_ff;
	assign stackPointer = stackPtr_ff;
	assign statusWord   = status_ff;
	assign bankSel      = {status_ff[dmd_pkg::BANK_SEL_HIGH_POS], status_ff[dmd_pkg::BANK_SEL_LOW_POS]};
	assign specRdEn     = specRd_ff;
	assign specWrEn     = specWr_ff;
	assign specAddr     = specAddr_ff;
	assign specWrData   = specWrData_ff;
endmodule // dmd_decoder
`default_nettype wire

// ===== test/dmd_decoder_chk.sv
// checker on the decoder top ports: stack pointer steps, steering, bit splits
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module dmd_decoder_chk (
	input wire logic               clk_sys,
	input wire logic               rst_b,
	input wire logic               accReq,
	input wire dmd_pkg::dmd_mode_t accMode,
	input wire logic               accIsBit,
	input wire logic               accWrite,
	input wire logic [7:0]         accAddr,
	input wire logic [7:0]         accWrData,
	input wire logic               pushReq,
	input wire logic               popReq,
	input wire logic               accReady,
	input wire logic               accDone,
	input wire logic [7:0]         accRdData,
	input wire logic [7:0]         stackPointer,
	input wire logic [7:0]         statusWord,
	input wire logic [1:0]         bankSel,
	input wire logic               specRdEn,
	input wire logic               specWrEn,
	input wire logic [7:0]         specAddr
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// request takes by kind
	sequence s_push; accReady && !accReq && pushReq; endsequence
	sequence s_pop; accReady && !accReq && !pushReq && popReq; endsequence
	sequence s_dirRd; accReady && accReq && accMode == dmd_pkg::MODE_DIRECT && !accWrite; endsequence
	sequence s_indir; accReady && accReq && accMode == dmd_pkg::MODE_INDIRECT; endsequence
	a_sp_reset: assert property ($rose(rst_b) |-> stackPointer == 8'h07)
		else $error("stack pointer not 07 after reset");
	a_bank_follow: assert property (bankSel == {statusWord[4], statusWord[3]})
		else $error("bank select differs from status bits");
	a_push_step: assert property (s_push |-> ##2 accDone && stackPointer == $past(stackPointer, 2) + 8'h01)
		else $error("push did not advance the pointer");
	a_pop_step: assert property (s_pop |-> ##3 accDone && stackPointer == $past(stackPointer, 3) - 8'h01)
		else $error("pop did not step the pointer back");
	a_spec_direct: assert property (s_dirRd ##0 !accIsBit && accAddr[7] && accAddr != 8'h81 && accAddr != 8'hD0
		|-> ##2 specRdEn && specAddr == $past(accAddr, 2))
		else $error("direct upper read not sent to special space");
	a_sp_direct: assert property (s_dirRd ##0 !accIsBit && accAddr == 8'h81
		|-> ##3 accDone && accRdData == $past(stackPointer, 3))
		else $error("stack pointer read wrong");
	a_stat_write: assert property (accReady && accReq && accWrite && !accIsBit && accAddr == 8'hD0
		&& accMode == dmd_pkg::MODE_DIRECT |-> ##2 statusWord == $past(accWrData, 2))
		else $error("status write lost");
	a_indir_ram: assert property (s_indir |-> (!specRdEn && !specWrEn) [*5])
		else $error("indirect access reached special space");
	a_bit_spec: assert property (s_dirRd ##0 accIsBit && accAddr[7] && accAddr[7:3] != 5'h1A
		|-> ##2 specRdEn && specAddr == ($past(accAddr, 2) & 8'hF8))
		else $error("special bit read at wrong register");
	a_bit_narrow: assert property (s_dirRd ##0 accIsBit |-> ##[3:5] accDone && accRdData[7:1] == 7'h00)
		else $error("bit read not confined to bit 0");
endmodule // dmd_decoder_chk
bind dmd_decoder dmd_decoder_chk u_dmd_decoder_chk (.clk_sys, .rst_b, .accReq, .accMode, .accIsBit, .accWrite,
	.accAddr, .accWrData, .pushReq, .popReq, .accReady, .accDone, .accRdData, .stackPointer, .statusWord,
	.bankSel, .specRdEn, .specWrEn, .specAddr);
`default_nettype wire

// ===== test/dmd_spec_model.sv
// peripheral register model behind the special-register strobes
// assumes read data is wanted only in the cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module dmd_spec_model (
	input  wire logic       clk_sys,
	input  wire logic       specRdEn,
	input  wire logic       specWrEn,
	input  wire logic [7:0] specAddr,
	input  wire logic [7:0] specWrData,
	output logic [7:0]      specRdData
);
	logic [7:0] regs [256];
	logic [7:0] held;
	logic [7:0] noise;
	logic       answer;
	// known starting pattern
	initial begin
		for (int i = 0; i < 256; i++) regs[i] = 8'(i) ^ 8'hA5;
		held = 8'h00;
		noise = 8'h5A;
		answer = 1'b0;
	end
	// strobes captured; noise flips every cycle
	always @(posedge clk_sys) begin
		if (specWrEn) regs[specAddr] <= specWrData;
		if (specRdEn) held <= regs[specAddr];
		answer <= specRdEn;
		noise <= ~noise;
	end
	// valid data stands one cycle only
	assign specRdData = answer ? held : held ^ noise;
endmodule // dmd_spec_model
`default_nettype wire

// ===== test/tb_data_memory_decoder.sv
// testbench for the data memory decoder: banks, halves, bits, stack, specials
// assumes the peripheral model answers the special-register strobes
`timescale 1ns/1ps
`default_nettype none
module tb_data_memory_decoder;
	localparam dmd_pkg::dmd_mode_t D = dmd_pkg::MODE_DIRECT;
	localparam dmd_pkg::dmd_mode_t I = dmd_pkg::MODE_INDIRECT;
	localparam dmd_pkg::dmd_mode_t R = dmd_pkg::MODE_REG;
	logic               clk_sys, rst_b, accReq, accIsBit, accWrite, pushReq, popReq;
	dmd_pkg::dmd_mode_t accMode;
	logic [7:0]         accAddr, accWrData, accRdData, stackPointer, statusWord;
	logic [7:0]         specAddr, specWrData, specRdData;
	logic               accReady, accDone, specRdEn, specWrEn;
	logic [1:0]         bankSel;
	int                 errors = 0;
	int                 checks = 0;
	int                 cycles = 0;
	dmd_decoder u_dmd_decoder (.clk_sys(clk_sys), .rst_b(rst_b), .accReq(accReq), .accMode(accMode),
		.accIsBit(accIsBit), .accWrite(accWrite), .accAddr(accAddr), .accWrData(accWrData),
		.pushReq(pushReq), .popReq(popReq), .accReady(accReady), .accDone(accDone),
		.accRdData(accRdData), .stackPointer(stackPointer), .statusWord(statusWord), .bankSel(bankSel),
		.specRdEn(specRdEn), .specWrEn(specWrEn), .specAddr(specAddr), .specWrData(specWrData),
		.specRdData(specRdData));
	dmd_spec_model u_dmd_spec_model (.clk_sys(clk_sys), .specRdEn(specRdEn), .specWrEn(specWrEn),
		.specAddr(specAddr), .specWrData(specWrData), .specRdData(specRdData));
	// clock and hang guard
	always #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			wrap_up();
		end
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// one request held to its take edge, then a bounded wait for done
	task automatic op(input int k, input dmd_pkg::dmd_mode_t m, input logic b, input logic w,
		input logic [7:0] a, input logic [7:0] d, input int lat);
		int n;
		accReq = (k == 0);
		pushReq = (k == 1);
		popReq = (k == 2);
		accMode = m;
		accIsBit = b;
		accWrite = w;
		accAddr = a;
		accWrData = d;
		@(posedge clk_sys);
		@(negedge clk_sys);
		{accReq, pushReq, popReq} = 3'h0;
		n = 1; // first look shows the take edge itself
		while (accDone !== 1'b1 && n < 8) begin
			@(negedge clk_sys);
			n++;
		end
		chk(8'(n), 8'(lat));
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		op(0, D, 1'b0, 1'b1, a, d, 2);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input int lat);
		op(0, D, 1'b0, 1'b0, a, 8'h00, lat);
		chk(accRdData, exp);
	endtask
	// reset values
	task automatic t_reset();
		chk(stackPointer, 8'h07);
		chk({6'h00, bankSel}, 8'h00);
	endtask
	// each bank selected in turn, register five written through it
	task automatic t_banks();
		for (int k = 0; k < 4; k++) begin
			wr(8'hD0, 8'(k << 3));
			chk({6'h00, bankSel}, 8'(k));
			op(0, R, 1'b0, 1'b1, 8'h05, 8'hB0 + 8'(k), 2);
		end
		op(0, R, 1'b0, 1'b0, 8'h05, 8'h00, 3);
		chk(accRdData, 8'hB3);
		for (int k = 0; k < 4; k++) rd(8'(k * 8 + 5), 8'hB0 + 8'(k), 3);
	endtask
	// pointers reach both RAM halves; direct upper goes to peripherals
	task automatic t_halves();
		wr(8'hD0, 8'h00);
		op(0, R, 1'b0, 1'b1, 8'h00, 8'hFF, 2);
		op(0, R, 1'b0, 1'b1, 8'h01, 8'h40, 2);
		op(0, I, 1'b0, 1'b1, 8'h00, 8'h5A, 3);
		op(0, I, 1'b0, 1'b1, 8'h01, 8'h33, 3);
		op(0, I, 1'b0, 1'b0, 8'h00, 8'h00, 4);
		chk(accRdData, 8'h5A);
		rd(8'h40, 8'h33, 3);
		rd(8'h98, 8'h98 ^ 8'hA5, 4);
		wr(8'hD0, 8'h10);
		op(0, R, 1'b0, 1'b1, 8'h01, 8'h41, 2);
		op(0, I, 1'b0, 1'b1, 8'h01, 8'h77, 3);
		rd(8'h41, 8'h77, 3);
		rd(8'h01, 8'h40, 3);
		wr(8'hD0, 8'h00);
	endtask
	// bit space in RAM and in the status word
	task automatic t_bits();
		wr(8'h22, 8'h00);
		wr(8'h20, 8'h00);
		op(0, D, 1'b1, 1'b1, 8'h13, 8'h01, 3);
		op(0, D, 1'b1, 1'b1, 8'h07, 8'h01, 3);
		rd(8'h22, 8'h08, 3);
		rd(8'h20, 8'h80, 3);
		op(0, D, 1'b1, 1'b0, 8'h13, 8'h00, 3);
		chk(accRdData, 8'h01);
		wr(8'h13, 8'hC3);
		rd(8'h13, 8'hC3, 3);
		op(0, D, 1'b1, 1'b1, 8'hD3, 8'h01, 3);
		chk({6'h00, bankSel}, 8'h01);
		wr(8'hD0, 8'h00);
	endtask
	// peripheral byte at 0x98 set through bit 0x99 by read-modify-write, read back
	task automatic t_spec();
		wr(8'h98, 8'h3C);
		op(0, D, 1'b1, 1'b1, 8'h99, 8'h01, 4);
		rd(8'h98, 8'h3E, 4);
		op(0, D, 1'b1, 1'b0, 8'h99, 8'h00, 4);
		chk(accRdData, 8'h01);
	endtask
	// push and pop order, pointer moved into the upper half and wrapped
	task automatic t_stack();
		op(1, D, 1'b0, 1'b0, 8'h00, 8'h11, 2);
		chk(stackPointer, 8'h08);
		rd(8'h08, 8'h11, 3);
		wr(8'h81, 8'hFE);
		rd(8'h81, 8'hFE, 3);
		op(1, D, 1'b0, 1'b0, 8'h00, 8'h22, 2);
		op(0, I, 1'b0, 1'b0, 8'h00, 8'h00, 4);
		chk(accRdData, 8'h22);
		op(1, D, 1'b0, 1'b0, 8'h00, 8'h33, 2);
		chk(stackPointer, 8'h00);
		op(2, D, 1'b0, 1'b0, 8'h00, 8'h00, 3);
		chk(accRdData, 8'h33);
		chk(stackPointer, 8'hFF);
		op(2, D, 1'b0, 1'b0, 8'h00, 8'h00, 3);
		chk(accRdData, 8'h22);
	endtask
	// main sequence
	initial begin
		{clk_sys, rst_b, accReq, accIsBit, accWrite, pushReq, popReq} = 7'h00;
		accMode = D;
		accAddr = 8'h00;
		accWrData = 8'h00;
		repeat (8) @(negedge clk_sys);
		rst_b = 1'b1;
		repeat (2) @(negedge clk_sys);
		t_reset();
		t_banks();
		t_halves();
		t_bits();
		t_spec();
		t_stack();
		wrap_up();
	end
endmodule // tb_data_memory_decoder
`default_nettype wire
